// ### common/bkpt_trace_pkg.sv
// Functional notes
// - Nine 32-bit breakpoint registers: address, mask, data, mask, four PC, PC mask.
// - Registers read and written by the serial debug channel and supervisor software.
// - Triggers combine address, data and PC matches; single or two-level.
// - A fired trigger halts the processor or raises a debug interrupt.
// - Critical interrupts still serviced while a debug interrupt runs in emulator mode.
// - Drive a 4-bit processor status bus and a 4-bit trace data bus.
// - Trace buses carry status, operands, branch targets at CPU rate; status clock toggles each CPU cycle (half rate).
// - All-status-ones flag is the AND of the four status bits.
package bkpt_trace_pkg;
  localparam int unsigned data_width = 32;
  localparam int unsigned reg_count = 9;
  localparam logic [3:0] idx_addr = 4'h0;
  localparam logic [3:0] idx_addr_mask = 4'h1;
  localparam logic [3:0] idx_data = 4'h2;
  localparam logic [3:0] idx_data_mask = 4'h3;
  localparam logic [3:0] idx_pc0 = 4'h4;
  localparam logic [3:0] idx_pc_mask = 4'h8;
  localparam logic [31:0] reg_reset = 32'h0000_0000;
  localparam logic [31:0] mask_reset = 32'hFFFF_FFFF;
  localparam logic [3:0] status_halted = 4'hF;
  localparam logic [3:0] status_idle = 4'h0;
  localparam logic [3:0] status_bkpt = 4'hE;
  localparam logic [3:0] status_operand = 4'h8;
  localparam logic [3:0] status_branch = 4'h5;
  localparam int unsigned sync_stages = 2;
  // Enable and mode bits of the trigger control word.
  localparam int unsigned ctl_addr_en = 0;
  localparam int unsigned ctl_data_en = 1;
  localparam int unsigned ctl_pc_en = 2;
  localparam int unsigned ctl_two_level = 3;
  localparam int unsigned ctl_halt = 4;
  localparam int unsigned ctl_l2_addr = 5;
  localparam int unsigned ctl_l2_data = 6;
  localparam int unsigned ctl_l2_pc = 7;
  typedef enum logic [1:0] {trig_idle, trig_armed, trig_level2} trig_state_type;
endpackage : bkpt_trace_pkg

// ### hw/masked_compare.sv
`timescale 1ns/1ps
`default_nettype none
module masked_compare (
  input wire logic [31:0] ref_value,
  input wire logic [31:0] mask_value,
  input wire logic [31:0] probe,
  output logic hit
);
  // A set mask bit removes that bit from the comparison.
  assign hit = ((ref_value ^ probe) & ~mask_value) == 32'h0000_0000;
endmodule : masked_compare
`default_nettype wire

// ### hw/breakpoint_trace_debug_unit.sv
`timescale 1ns/1ps
`default_nettype none
module breakpoint_trace_debug_unit (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic link_wr,
  input wire logic [3:0] link_index,
  input wire logic [31:0] link_wdata,
  output logic [31:0] link_rdata,
  input wire logic sup_wr,
  input wire logic [3:0] sup_index,
  input wire logic [31:0] sup_wdata,
  output logic [31:0] sup_rdata,
  input wire logic supervisor_mode,
  input wire logic [7:0] trigger_ctl,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_data,
  input wire logic insn_valid,
  input wire logic [31:0] insn_pc,
  input wire logic [3:0] cpu_status,
  input wire logic operand_valid,
  input wire logic [31:0] operand_data,
  input wire logic branch_valid,
  input wire logic [31:0] branch_target,
  input wire logic emulator_mode,
  input wire logic critical_irq,
  input wire logic halt_release,
  output logic halt_req,
  output logic debug_irq,
  output logic critical_irq_grant,
  output logic [3:0] processor_status_bus,
  output logic [3:0] trace_data_bus,
  output logic status_bus_clock,
  output logic all_status_ones_flag
);
  logic [31:0] bkpt_q [bkpt_trace_pkg::reg_count];
  logic hit_addr, hit_data;
  logic [3:0] hit_pc;
  logic l1_match, l2_match, fire;
  logic emu_s1_q, emu_s2_q, crit_s1_q, crit_s2_q, rel_s1_q, rel_s2_q;
  bkpt_trace_pkg::trig_state_type trig_q;

  // Link side: request toggles cross into the CPU domain, data held stable.
  logic link_tog_q;
  logic [3:0] link_idx_q;
  logic [31:0] link_dat_q;
  logic ltog_s1_q, ltog_s2_q, ltog_s3_q;
  logic [31:0] rd_shadow_q;
  logic [31:0] rd_l1_q, rd_l2_q;
  logic [31:0] rd_l3_q;
  logic [3:0] rd_idx_q;
  logic ack_s1_q, ack_s2_q;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      link_tog_q <= 1'b0;
      link_idx_q <= 4'h0;
      link_dat_q <= bkpt_trace_pkg::reg_reset;
    end else if (link_wr && (ack_s2_q == link_tog_q)) begin
      link_tog_q <= ~link_tog_q;
      link_idx_q <= link_index;
      link_dat_q <= link_wdata;
    end
  end

  // The acknowledge toggle returns to the link clock through two stages.
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ltog_s3_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // Readback to the link: the shadow word passes three stages and is taken once two samples agree.
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      rd_l1_q <= bkpt_trace_pkg::reg_reset;
      rd_l2_q <= bkpt_trace_pkg::reg_reset;
      rd_l3_q <= bkpt_trace_pkg::reg_reset;
      link_rdata <= bkpt_trace_pkg::reg_reset;
    end else begin
      rd_l1_q <= rd_shadow_q;
      rd_l2_q <= rd_l1_q;
      rd_l3_q <= rd_l2_q;
      if (rd_l3_q == rd_l2_q) begin
        link_rdata <= rd_l3_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ltog_s1_q <= 1'b0;
      ltog_s2_q <= 1'b0;
      ltog_s3_q <= 1'b0;
    end else begin
      ltog_s1_q <= link_tog_q;
      ltog_s2_q <= ltog_s1_q;
      ltog_s3_q <= ltog_s2_q;
    end
  end

  // Register file; the link write wins over a supervisor write in the same cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < bkpt_trace_pkg::reg_count; i++) begin
        bkpt_q[i] <= (i == 1 || i == 3 || i == 8) ? bkpt_trace_pkg::mask_reset
                                                   : bkpt_trace_pkg::reg_reset;
      end
    end else if ((ltog_s3_q != ltog_s2_q) && (link_idx_q < 4'd9)) begin
      bkpt_q[link_idx_q] <= link_dat_q;
    end else if (sup_wr && supervisor_mode && (sup_index < 4'd9)) begin
      bkpt_q[sup_index] <= sup_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sup_rdata <= bkpt_trace_pkg::reg_reset;
      rd_shadow_q <= bkpt_trace_pkg::reg_reset;
      rd_idx_q <= 4'h0;
    end else begin
      sup_rdata <= (supervisor_mode && sup_index < 4'd9) ? bkpt_q[sup_index]
                                                         : bkpt_trace_pkg::reg_reset;
      // The link reads back the register it last wrote; the index crosses with that write.
      if (ltog_s3_q != ltog_s2_q) begin
        rd_idx_q <= link_idx_q;
      end
      rd_shadow_q <= (rd_idx_q < 4'd9) ? bkpt_q[rd_idx_q]
                                       : bkpt_trace_pkg::reg_reset;
    end
  end

  masked_compare u_addr (
    .ref_value(bkpt_q[bkpt_trace_pkg::idx_addr]),
    .mask_value(bkpt_q[bkpt_trace_pkg::idx_addr_mask]),
    .probe(bus_addr),
    .hit(hit_addr)
  );
  masked_compare u_data (
    .ref_value(bkpt_q[bkpt_trace_pkg::idx_data]),
    .mask_value(bkpt_q[bkpt_trace_pkg::idx_data_mask]),
    .probe(bus_data),
    .hit(hit_data)
  );
  for (genvar g = 0; g < 4; g++) begin : g_pc
    masked_compare u_pc (
      .ref_value(bkpt_q[4 + g]),
      .mask_value(bkpt_q[bkpt_trace_pkg::idx_pc_mask]),
      .probe(insn_pc),
      .hit(hit_pc[g])
    );
  end

  // Each enabled condition must hold; at least one condition must be enabled.
  function automatic logic cond_hit(input logic en_a, input logic en_d, input logic en_p,
                                    input logic ba, input logic bd, input logic ip,
                                    input logic ha, input logic hd, input logic hp);
    cond_hit = (en_a || en_d || en_p) && (!en_a || (ba && ha)) && (!en_d || (ba && hd))
               && (!en_p || (ip && hp));
  endfunction : cond_hit

  assign l1_match = cond_hit(trigger_ctl[bkpt_trace_pkg::ctl_addr_en],
                             trigger_ctl[bkpt_trace_pkg::ctl_data_en],
                             trigger_ctl[bkpt_trace_pkg::ctl_pc_en],
                             bus_valid, bus_valid, insn_valid,
                             hit_addr, hit_data, |hit_pc);
  assign l2_match = cond_hit(trigger_ctl[bkpt_trace_pkg::ctl_l2_addr],
                             trigger_ctl[bkpt_trace_pkg::ctl_l2_data],
                             trigger_ctl[bkpt_trace_pkg::ctl_l2_pc],
                             bus_valid, bus_valid, insn_valid,
                             hit_addr, hit_data, |hit_pc);
  assign fire = trigger_ctl[bkpt_trace_pkg::ctl_two_level]
                ? (trig_q == bkpt_trace_pkg::trig_level2) && l2_match
                : (trig_q == bkpt_trace_pkg::trig_armed) && l1_match;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trig_q <= bkpt_trace_pkg::trig_idle;
    end else begin
      case (trig_q)
        bkpt_trace_pkg::trig_idle: trig_q <= bkpt_trace_pkg::trig_armed;
        bkpt_trace_pkg::trig_armed: begin
          if (trigger_ctl[bkpt_trace_pkg::ctl_two_level] && l1_match) begin
            trig_q <= bkpt_trace_pkg::trig_level2;
          end
        end
        bkpt_trace_pkg::trig_level2: begin
          if (!trigger_ctl[bkpt_trace_pkg::ctl_two_level] || fire) begin
            trig_q <= bkpt_trace_pkg::trig_armed;
          end
        end
        default: trig_q <= bkpt_trace_pkg::trig_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      emu_s1_q <= 1'b0;
      emu_s2_q <= 1'b0;
      crit_s1_q <= 1'b0;
      crit_s2_q <= 1'b0;
      rel_s1_q <= 1'b0;
      rel_s2_q <= 1'b0;
    end else begin
      emu_s1_q <= emulator_mode;
      emu_s2_q <= emu_s1_q;
      crit_s1_q <= critical_irq;
      crit_s2_q <= crit_s1_q;
      rel_s1_q <= halt_release;
      rel_s2_q <= rel_s1_q;
    end
  end

  // Halt holds until released; a new fire wins over the release.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      halt_req <= 1'b0;
      debug_irq <= 1'b0;
    end else begin
      if (fire && trigger_ctl[bkpt_trace_pkg::ctl_halt]) begin
        halt_req <= 1'b1;
      end else if (rel_s2_q) begin
        halt_req <= 1'b0;
      end
      debug_irq <= fire && !trigger_ctl[bkpt_trace_pkg::ctl_halt];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      critical_irq_grant <= 1'b0;
    end else begin
      critical_irq_grant <= crit_s2_q && (emu_s2_q || !halt_req);
    end
  end

  // Trace: status each cycle; operands and branch targets go out in nibbles.
  logic [31:0] trace_word_q;
  logic [3:0] trace_left_q;
  logic [3:0] status_d;

  always_comb begin
    if (halt_req) begin
      status_d = bkpt_trace_pkg::status_halted;
    end else if (fire) begin
      status_d = bkpt_trace_pkg::status_bkpt;
    end else if (branch_valid && trace_left_q == 4'h0) begin
      status_d = bkpt_trace_pkg::status_branch;
    end else if (operand_valid && trace_left_q == 4'h0) begin
      status_d = bkpt_trace_pkg::status_operand;
    end else begin
      status_d = cpu_status;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trace_word_q <= bkpt_trace_pkg::reg_reset;
      trace_left_q <= 4'h0;
      trace_data_bus <= 4'h0;
    end else if (trace_left_q != 4'h0) begin
      trace_data_bus <= trace_word_q[3:0];
      trace_word_q <= {4'h0, trace_word_q[31:4]};
      trace_left_q <= trace_left_q - 4'h1;
    end else if (!halt_req && branch_valid) begin
      trace_word_q <= branch_target;
      trace_left_q <= 4'h8;
      trace_data_bus <= 4'h0;
    end else if (!halt_req && operand_valid) begin
      trace_word_q <= operand_data;
      trace_left_q <= 4'h8;
      trace_data_bus <= 4'h0;
    end else begin
      trace_data_bus <= 4'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      processor_status_bus <= bkpt_trace_pkg::status_idle;
      all_status_ones_flag <= 1'b0;
      status_bus_clock <= 1'b0;
    end else begin
      processor_status_bus <= status_d;
      all_status_ones_flag <= &status_d;
      status_bus_clock <= ~status_bus_clock;
    end
  end
endmodule : breakpoint_trace_debug_unit
`default_nettype wire

// ### test/debug_probe_model.sv
`timescale 1ns/1ps
`default_nettype none
module debug_probe_model (
  input wire logic clk_on,
  input wire logic go,
  input wire logic [3:0] idx,
  input wire logic [31:0] data,
  output logic link_clk,
  output logic link_wr,
  output logic [3:0] link_index,
  output logic [31:0] link_wdata,
  output logic done
);
  initial link_clk = 1'b0;
  always #7.5 link_clk = clk_on ? !link_clk : 1'b0;
  // One write per request, held one link cycle, then spaced past the crossing.
  initial begin
    link_wr = 1'b0;
    link_index = 4'h0;
    link_wdata = 32'h0000_0000;
    done = 1'b0;
    forever begin
      @(posedge link_clk);
      if (go && !done) begin
        link_wr <= 1'b1;
        link_index <= idx;
        link_wdata <= data;
        @(posedge link_clk);
        link_wr <= 1'b0;
        link_wdata <= ~data;
        repeat (20) @(posedge link_clk);
        done <= 1'b1;
      end else if (!go) begin
        done <= 1'b0;
      end
    end
  end
endmodule : debug_probe_model
`default_nettype wire

// ### test/breakpoint_trace_debug_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bkpt_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] sup_index,
  input wire logic [31:0] sup_rdata,
  input wire logic supervisor_mode,
  input wire logic [7:0] trigger_ctl,
  input wire logic critical_irq,
  input wire logic halt_req,
  input wire logic debug_irq,
  input wire logic critical_irq_grant,
  input wire logic [3:0] processor_status_bus,
  input wire logic status_bus_clock,
  input wire logic all_status_ones_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ones_and: assert property (all_status_ones_flag == &processor_status_bus)
    else $error("ones flag differs from status AND");
  a_clk_toggle: assert property ($past(rstn) |-> status_bus_clock != $past(status_bus_clock))
    else $error("status clock stalled");
  a_irq_pulse: assert property (debug_irq |=> !debug_irq)
    else $error("debug irq longer than one cycle");
  a_irq_mode: assert property (debug_irq |-> !$past(trigger_ctl[4]))
    else $error("debug irq in halt mode");
  a_halt_mode: assert property ($rose(halt_req) |-> $past(trigger_ctl[4]))
    else $error("halt in irq mode");
  a_halt_holds: assert property ($rose(halt_req) |=> halt_req)
    else $error("halt dropped at once");
  a_sup_gate: assert property (!supervisor_mode |=> sup_rdata == 32'h0000_0000)
    else $error("read data outside supervisor mode");
  a_index_cap: assert property (sup_index > 4'h8 |=> sup_rdata == 32'h0000_0000)
    else $error("read data from unmapped index");
  a_grant_cause: assert property ($rose(critical_irq_grant) |->
    $past(critical_irq, 2) || $past(critical_irq, 3) || $past(critical_irq, 4))
    else $error("grant without critical irq");
  cover property ($rose(halt_req));
  cover property (debug_irq);
  cover property ($rose(critical_irq_grant));
endmodule : bkpt_checker
bind breakpoint_trace_debug_unit bkpt_checker i_bkpt_checker (.sys_clk, .rstn, .sup_index,
  .sup_rdata, .supervisor_mode, .trigger_ctl, .critical_irq, .halt_req, .debug_irq,
  .critical_irq_grant, .processor_status_bus, .status_bus_clock, .all_status_ones_flag);
`default_nettype wire

// ### test/breakpoint_trace_debug_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module breakpoint_trace_debug_unit_test;
  logic sys_clk = 1'b0;
  logic rstn, clk_on, go, done, link_clk, link_wr, sup_wr, supervisor_mode, bus_valid;
  logic insn_valid, operand_valid, branch_valid, emulator_mode, critical_irq, halt_release;
  logic halt_req, debug_irq, critical_irq_grant, status_bus_clock, all_status_ones_flag;
  logic [1:0] seen;
  logic [3:0] link_index, sup_index, cpu_status, pidx, processor_status_bus, trace_data_bus;
  logic [7:0] trigger_ctl;
  logic [31:0] link_wdata, link_rdata, sup_wdata, sup_rdata, bus_addr, bus_data, insn_pc;
  logic [31:0] operand_data, branch_target, pdata, t, p;
  logic [31:0] shadow [9];
  int mismatches = 0;
  int n_checks = 0;
  always #12.5 sys_clk = !sys_clk;
  breakpoint_trace_debug_unit i_breakpoint_trace_debug_unit (.sys_clk, .rstn, .link_clk,
    .link_wr, .link_index, .link_wdata, .link_rdata, .sup_wr, .sup_index, .sup_wdata,
    .sup_rdata, .supervisor_mode, .trigger_ctl, .bus_valid, .bus_addr, .bus_data, .insn_valid,
    .insn_pc, .cpu_status, .operand_valid, .operand_data, .branch_valid, .branch_target,
    .emulator_mode, .critical_irq, .halt_release, .halt_req, .debug_irq, .critical_irq_grant,
    .processor_status_bus, .trace_data_bus, .status_bus_clock, .all_status_ones_flag);
  debug_probe_model i_debug_probe_model (.clk_on, .go, .idx(pidx), .data(pdata), .link_clk,
    .link_wr, .link_index, .link_wdata, .done);
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic sup_write(input logic [3:0] i, input logic [31:0] d);
    @(posedge sys_clk);
    sup_wr <= 1'b1;
    sup_index <= i;
    sup_wdata <= d;
    @(posedge sys_clk);
    sup_wr <= 1'b0;
  endtask : sup_write
  task automatic sup_read(input logic [3:0] i, input logic [31:0] e);
    @(posedge sys_clk);
    sup_index <= i;
    @(posedge sys_clk);
    #1 check("sup_rdata", e, sup_rdata);
  endtask : sup_read
  task automatic probe(input logic av, input logic pv, input logic [1:0] e);
    @(posedge sys_clk);
    bus_valid <= av;
    insn_valid <= pv;
    @(posedge sys_clk);
    bus_valid <= 1'b0;
    insn_valid <= 1'b0;
    #1 seen = {halt_req, debug_irq};
    repeat (6) begin
      @(posedge sys_clk);
      #1 seen |= {halt_req, debug_irq};
    end
    check("halt_irq", 32'(e), 32'(seen));
  endtask : probe
  initial begin
    #2_000_000 check("run_time", 32'h0000_0000, 32'h0000_0001);
    results();
  end
  initial begin
    void'($urandom(32'h4f55));
    {rstn, go, sup_wr, supervisor_mode, bus_valid, insn_valid, operand_valid} = '0;
    {branch_valid, emulator_mode, critical_irq, halt_release, trigger_ctl, pidx} = '0;
    {sup_index, sup_wdata, bus_addr, bus_data, insn_pc, operand_data, branch_target} = '0;
    {pdata, cpu_status} = '0;
    clk_on = 1'b1;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    clk_on <= 1'b0;
    supervisor_mode <= 1'b1;
    for (int i = 0; i < 9; i++) sup_read(4'(i), (i == 1 || i == 3 || i == 8) ? '1 : '0);
    for (int i = 0; i < 9; i++) begin
      shadow[i] = $urandom();
      sup_write(4'(i), shadow[i]);
    end
    for (int i = 0; i < 9; i++) sup_read(4'(i), shadow[i]);
    sup_write(4'h9, $urandom());
    sup_read(4'h9, 32'h0000_0000);
    supervisor_mode <= 1'b0;
    sup_write(4'h0, ~shadow[0]);
    sup_read(4'h0, 32'h0000_0000);
    supervisor_mode <= 1'b1;
    sup_read(4'h0, shadow[0]);
    $display("test registers done");
    t = $urandom();
    clk_on <= 1'b1;
    pidx <= 4'h6;
    pdata <= t;
    go <= 1'b1;
    for (int k = 0; k < 60 && done !== 1'b1; k++) @(posedge sys_clk);
    check("link_done", 32'h0000_0001, 32'(done));
    check("link_rdata", t, link_rdata);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
    clk_on <= 1'b0;
    sup_read(4'h6, t);
    $display("test link done");
    t = $urandom();
    p = $urandom();
    sup_write(4'h0, t);
    sup_write(4'h1, 32'hFFFF_FF00);
    sup_write(4'h4, p);
    sup_write(4'h8, 32'hFFFF_FFFF);
    cpu_status <= 4'($urandom());
    bus_addr <= t ^ 32'h0000_00A5;
    insn_pc <= p;
    trigger_ctl <= 8'h11;
    probe(1'b1, 1'b0, 2'b00);
    bus_addr <= t ^ 32'h0000_0100;
    probe(1'b1, 1'b0, 2'b10);
    check("halted", 32'(bkpt_trace_pkg::status_halted), 32'(processor_status_bus));
    check("ones_flag", 32'h0000_0001, 32'(all_status_ones_flag));
    halt_release <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check("released", 32'h0000_0000, 32'(halt_req));
    halt_release <= 1'b0;
    trigger_ctl <= 8'h04;
    probe(1'b0, 1'b1, 2'b01);
    trigger_ctl <= 8'h89;
    probe(1'b0, 1'b1, 2'b00);
    probe(1'b1, 1'b0, 2'b00);
    probe(1'b0, 1'b1, 2'b01);
    $display("test triggers done");
    trigger_ctl <= 8'h00;
    for (int n = 0; n < 4; n++) begin
      t = $urandom();
      p = 32'(n[0] ? bkpt_trace_pkg::status_operand : bkpt_trace_pkg::status_branch);
      @(posedge sys_clk);
      branch_valid <= !n[0];
      operand_valid <= n[0];
      branch_target <= t;
      operand_data <= t;
      @(posedge sys_clk);
      branch_valid <= 1'b0;
      operand_valid <= 1'b0;
      #1 check("status", p, 32'(processor_status_bus));
      for (int i = 0; i < 8; i++) begin
        @(posedge sys_clk);
        #1 check("nibble", 32'(t[4*i+:4]), 32'(trace_data_bus));
      end
    end
    $display("test trace done");
    emulator_mode <= 1'b1;
    critical_irq <= 1'b1;
    for (int k = 0; k < 8 && critical_irq_grant !== 1'b1; k++) @(posedge sys_clk);
    #1 check("grant", 32'h0000_0001, 32'(critical_irq_grant));
    $display("test emulator done");
    results();
  end
endmodule : breakpoint_trace_debug_unit_test
`default_nettype wire
